// File: core/gpio_ports.sv
// four bidirectional io ports with avalon-mm register access
// Summary of operation
// - direction bit one makes pin input; zero drives it push-pull
// - written output data held in latch, pins keep it until rewritten
// - inputs unlatched; read samples live synchronised pin levels at request edge
// - reading an output bit returns its latch, not the pin level
// - reset sets all data latches and direction bits to ones
// - direction written byte-wide or by single-bit set and clear
// - single-bit set or clear of data reads port, changes bit, writes whole byte back; of direction it reads the direction byte
// - per-port weak pull-up enable, active only while pin is input
// - halt enters power-down, system clock stopped until wake-up
// - falling edge on wake-enabled port a pin wakes the device
// - wake-up selectable per port a pin; others never wake
// - active-low external interrupt on port a bit 5 when shared and input
// - port c bits shared as analog switch inputs, four in small variant
// - port d bits 0 to 3 shared as converter oscillator pins
// - 28 io lines in ports a to d, all 28 kept in small variant
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none

module gpio_ports
	import gpio_pkg::*;
#(
	parameter bit SMALL_VARIANT = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// port pins
	input wire pins_s pin_i,
	output pins_s pin_o,
	output pins_s pin_oe_n,
	output pins_s pull_en,
	// shared functions
	output logic ext_int_n,
	output logic [7:0] analog_switch_lines,
	input wire logic [3:0] osc_drive,
	input wire logic [3:0] osc_drive_oe_n,
	output logic [3:0] osc_sense,
	// power and interrupt
	output logic sys_clk_en,
	output logic irq
);

	// ********************
	// helpers
	// ********************
	function automatic logic [7:0] pin_byte(input logic [27:0] v, input logic [1:0] i);
		logic [7:0] r;
		r = 8'h00;
		case (i)
			2'd0: r = v[7:0];
			2'd1: r = v[15:8];
			2'd2: r = v[23:16];
			default: r = {4'h0, v[27:24]};
		endcase
		return r;
	endfunction

	// input bits read the pin, output bits read the latch
	function automatic logic [7:0] port_val(input logic [7:0] dir, input logic [7:0] lat,
		input logic [7:0] pin, input logic [7:0] msk);
		return ((dir & pin) | (~dir & lat)) & msk;
	endfunction

	function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] b,
		input logic s);
		logic [7:0] r;
		r = v;
		r[b] = s;
		return r;
	endfunction

	// ********************
	// state
	// ********************
	bus_e bus_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_d;
	logic [3:0][7:0] lat_q;
	logic [3:0][7:0] dir_q;
	opt_s opt_q;
	logic [27:0] sync1_q;
	logic [27:0] sync2_q;
	logic [27:0] prev_q;
	logic sleep_q;
	logic [1:0] stat_q;
	logic [1:0] mask_q;

	logic take_rd;
	logic do_wr;
	logic [1:0] idx;
	logic [1:0] bp;
	logic [2:0] bb;
	logic [7:0] cur_val;
	logic [27:0] fall;
	logic [27:0] dirv;
	logic [27:0] latv;
	logic [27:0] shr;
	logic [7:0] c_eff;
	logic wake;
	logic int_act;
	logic ext_ev;

	// ********************
	// bus handshake
	// ********************
	assign avs_waitrequest = (avs_read | avs_write) & (bus_q != BUS_RESP);
	assign take_rd = avs_read & (bus_q == BUS_IDLE);
	assign do_wr = avs_write & (bus_q == BUS_RESP) & avs_byteenable[0];
	assign avs_readdata = rdata_q;
	assign idx = avs_address[3:2];
	assign bp = avs_writedata[BITOP_PORT +: 2];
	assign bb = avs_writedata[2:0];

	always_ff @(posedge clk) begin
		if (srst) begin
			bus_q <= BUS_IDLE;
		end else begin
			unique case (bus_q)
				BUS_IDLE: if (avs_read | avs_write) begin
					bus_q <= BUS_RESP;
				end
				BUS_RESP: bus_q <= BUS_IDLE;
				default: bus_q <= BUS_IDLE;
			endcase
		end
	end

	// ********************
	// pin synchronisers
	// ********************
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_q <= SYNC_RST;
			sync2_q <= SYNC_RST;
			prev_q <= SYNC_RST;
		end else begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	assign fall = prev_q & ~sync2_q;
	assign cur_val = port_val(dir_q[bp], lat_q[bp], pin_byte(sync2_q, bp), PORT_MASK[bp]);

	// ********************
	// read path
	// ********************
	always_comb begin
		rd_d = 32'h00000000;
		if (avs_address[7:4] == ADDR_DATA[7:4]) begin
			rd_d[7:0] = port_val(dir_q[idx], lat_q[idx], pin_byte(sync2_q, idx),
				PORT_MASK[idx]);
		end else if (avs_address[7:4] == ADDR_DIR[7:4]) begin
			rd_d[7:0] = dir_q[idx] & PORT_MASK[idx];
		end else begin
			case ({avs_address[7:2], 2'b00})
				ADDR_OPT0: rd_d[15:0] = {opt_q.wake_en, 3'h0, opt_q.int_share, opt_q.pull};
				ADDR_OPT1: rd_d[11:0] = {opt_q.d_share, opt_q.c_share};
				ADDR_PWR: rd_d[0] = sleep_q;
				ADDR_STAT: rd_d[1:0] = stat_q;
				ADDR_MASK: rd_d[1:0] = mask_q;
				default: rd_d = 32'h00000000;
			endcase
		end
	end

	// pins sampled at the edge that takes the read
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= RDATA_RST;
		end else if (take_rd) begin
			rdata_q <= rd_d;
		end
	end

	// ********************
	// output latches
	// ********************
	always_ff @(posedge clk) begin
		if (srst) begin
			lat_q <= PORT_MASK;
		end else if (do_wr && avs_address[7:4] == ADDR_DATA[7:4]) begin
			lat_q[idx] <= avs_writedata[7:0] & PORT_MASK[idx];
		end else if (do_wr && avs_address == ADDR_BITOP && !avs_writedata[BITOP_DIR]) begin
			lat_q[bp] <= put_bit(cur_val, bb, avs_writedata[BITOP_VAL]) & PORT_MASK[bp];
		end
	end

	// ********************
	// direction registers
	// ********************
	always_ff @(posedge clk) begin
		if (srst) begin
			dir_q <= PORT_MASK;
		end else if (do_wr && avs_address[7:4] == ADDR_DIR[7:4]) begin
			dir_q[idx] <= avs_writedata[7:0] & PORT_MASK[idx];
		end else if (do_wr && avs_address == ADDR_BITOP && avs_writedata[BITOP_DIR]) begin
			dir_q[bp] <= put_bit(dir_q[bp], bb, avs_writedata[BITOP_VAL]) & PORT_MASK[bp];
		end
	end

	// ********************
	// configuration options
	// ********************
	always_ff @(posedge clk) begin
		if (srst) begin
			opt_q <= OPT_RST;
		end else if (avs_write && bus_q == BUS_RESP) begin
			if (avs_address == ADDR_OPT0) begin
				if (avs_byteenable[0]) begin
					opt_q.pull <= avs_writedata[3:0];
					opt_q.int_share <= avs_writedata[OPT0_INT];
				end
				if (avs_byteenable[1]) begin
					opt_q.wake_en <= avs_writedata[OPT0_WAKE +: 8];
				end
			end else if (avs_address == ADDR_OPT1) begin
				if (avs_byteenable[0]) begin
					opt_q.c_share <= avs_writedata[7:0];
				end
				if (avs_byteenable[1]) begin
					opt_q.d_share <= avs_writedata[OPT1_DSHR +: 4];
				end
			end
		end
	end

	// ********************
	// pin drive and sharing
	// ********************
	assign c_eff = SMALL_VARIANT ? (opt_q.c_share & C_MASK_SMALL) : opt_q.c_share;
	assign dirv = {dir_q[3][3:0], dir_q[2], dir_q[1], dir_q[0]};
	assign latv = {lat_q[3][3:0], lat_q[2], lat_q[1], lat_q[0]};
	assign shr = {opt_q.d_share, c_eff, 8'h00, 2'b00, opt_q.int_share, 5'h00};

	// oe_n follows the direction bit; shared pins lose the port driver
	assign pin_oe_n = pins_s'(dirv | shr) & pins_s'({~opt_q.d_share, 24'hffffff})
		| pins_s'({opt_q.d_share & osc_drive_oe_n, 24'h000000});
	assign pin_o = pins_s'({opt_q.d_share & osc_drive | ~opt_q.d_share & latv[27:24],
		latv[23:0]});
	// the interrupt pin is a plain input and keeps its port pull-up
	assign pull_en = pins_s'({{4{opt_q.pull[3]}}, {8{opt_q.pull[2]}}, {8{opt_q.pull[1]}},
		{8{opt_q.pull[0]}}} & dirv & ~{opt_q.d_share, c_eff, 16'h0000});
	assign analog_switch_lines = sync2_q[23:16] & c_eff;
	assign osc_sense = sync2_q[27:24] & opt_q.d_share;
	assign int_act = opt_q.int_share & dir_q[0][PA_INT_BIT];
	assign ext_int_n = int_act ? sync2_q[PA_INT_BIT] : 1'b1;
	assign ext_ev = int_act & fall[PA_INT_BIT];

	// ********************
	// power-down and wake-up
	// ********************
	assign wake = sleep_q & (|(fall[7:0] & opt_q.wake_en));
	assign sys_clk_en = ~sleep_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			sleep_q <= 1'b0;
		end else if (wake) begin
			sleep_q <= 1'b0;
		end else if (do_wr && avs_address == ADDR_PWR && avs_writedata[0]) begin
			sleep_q <= 1'b1;
		end
	end

	// ********************
	// interrupt status and mask
	// ********************
	always_ff @(posedge clk) begin
		if (srst) begin
			stat_q <= IRQ_RST;
		end else begin
			stat_q[ST_WAKE] <= (stat_q[ST_WAKE] & ~(do_wr && avs_address == ADDR_STAT
				&& avs_writedata[ST_WAKE])) | wake;
			stat_q[ST_EXT] <= (stat_q[ST_EXT] & ~(do_wr && avs_address == ADDR_STAT
				&& avs_writedata[ST_EXT])) | ext_ev;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mask_q <= IRQ_RST;
		end else if (do_wr && avs_address == ADDR_MASK) begin
			mask_q <= avs_writedata[1:0];
		end
	end

	assign irq = |(stat_q & mask_q);

	// ********************
	// assertions
	// ********************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	chk_out_drive: assert property ((~dirv & ~shr & (pin_oe_n | (pin_o ^ latv))) == 28'h0)
		else $error("output pin not driven from latch");
	chk_in_float: assert property (((dirv & ~shr) & ~pin_oe_n) == 28'h0)
		else $error("input pin is driven");
	chk_latch_hold: assert property (!do_wr |=> $stable(lat_q))
		else $error("latch changed without a write");
	chk_read_pin: assert property (take_rd && avs_address == ADDR_DATA && dir_q[0] == 8'hff
		|=> avs_readdata[7:0] == $past(sync2_q[7:0]))
		else $error("input read not pin level");
	chk_read_latch: assert property (take_rd && avs_address == ADDR_DATA && dir_q[0] == 8'h00
		|=> avs_readdata[7:0] == $past(lat_q[0]))
		else $error("output read not latch");
	chk_reset_ones: assert property ($past(srst) |-> lat_q == PORT_MASK && dir_q == PORT_MASK)
		else $error("ports not ones after reset");
	chk_dir_bit: assert property (do_wr && avs_address == ADDR_BITOP && avs_writedata[BITOP_DIR]
		&& !(bp == 2'd3 && bb[2])
		|=> dir_q[$past(bp)][$past(bb)] == $past(avs_writedata[BITOP_VAL]))
		else $error("direction bit op failed");
	chk_bit_rmw: assert property (do_wr && avs_address == ADDR_BITOP && !avs_writedata[BITOP_DIR]
		|=> lat_q[$past(bp)] == (put_bit($past(cur_val), $past(bb), $past(avs_writedata[BITOP_VAL]))
		& PORT_MASK[$past(bp)]))
		else $error("bit op not read-modify-write");
	chk_pull_input: assert property ((pull_en & ~dirv) == 28'h0)
		else $error("pull-up on output pin");
	chk_halt_sleep: assert property (do_wr && avs_address == ADDR_PWR && avs_writedata[0] && !wake
		|=> sleep_q && !sys_clk_en)
		else $error("halt did not power down");
	chk_wake_fall: assert property (sleep_q && |(fall[7:0] & opt_q.wake_en)
		|=> !sleep_q && stat_q[ST_WAKE])
		else $error("no wake on falling edge");
	chk_no_wake: assert property (sleep_q && !(|(fall[7:0] & opt_q.wake_en)) |=> sleep_q)
		else $error("wake from disabled pin");
	chk_int_share: assert property (!int_act |-> ext_int_n)
		else $error("external interrupt active while not shared");
	chk_share_drive: assert property ((shr[23:0] & ~pin_oe_n[23:0]) == 24'h0)
		else $error("shared pin still driven");
	chk_bus_wait: assert property ((avs_read | avs_write) && bus_q == BUS_IDLE
		|-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait cycle");

	cov_wake: cover property (sleep_q ##1 !sleep_q);
	cov_bit_rmw: cover property (do_wr && avs_address == ADDR_BITOP);
	cov_ext_irq: cover property (ext_ev ##1 irq);

endmodule

`default_nettype wire

// File: pkg/gpio_pkg.sv
// constants, types and register map of the bidirectional io port block
package gpio_pkg;

	// ********************
	// register byte addresses
	// ********************
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_DIR = 8'h10;
	localparam logic [7:0] ADDR_BITOP = 8'h20;
	localparam logic [7:0] ADDR_OPT0 = 8'h24;
	localparam logic [7:0] ADDR_OPT1 = 8'h28;
	localparam logic [7:0] ADDR_PWR = 8'h2c;
	localparam logic [7:0] ADDR_STAT = 8'h30;
	localparam logic [7:0] ADDR_MASK = 8'h34;

	// ********************
	// field positions
	// ********************
	localparam int BITOP_PORT = 4;
	localparam int BITOP_DIR = 6;
	localparam int BITOP_VAL = 7;
	localparam int OPT0_INT = 4;
	localparam int OPT0_WAKE = 8;
	localparam int OPT1_DSHR = 8;
	localparam int PA_INT_BIT = 5;
	localparam int ST_WAKE = 0;
	localparam int ST_EXT = 1;

	// ********************
	// reset values and widths
	// ********************
	localparam logic [3:0][7:0] PORT_MASK = {8'h0f, 8'hff, 8'hff, 8'hff};
	localparam logic [7:0] C_MASK_SMALL = 8'h0f;
	localparam logic [27:0] SYNC_RST = 28'hfffffff;
	localparam logic [1:0] IRQ_RST = 2'h0;
	localparam logic [31:0] RDATA_RST = 32'h00000000;

	// ********************
	// types
	// ********************
	typedef struct packed {
		logic [3:0] d;
		logic [7:0] c;
		logic [7:0] b;
		logic [7:0] a;
	} pins_s;

	typedef struct packed {
		logic [3:0] pull;
		logic int_share;
		logic [7:0] wake_en;
		logic [7:0] c_share;
		logic [3:0] d_share;
	} opt_s;

	localparam opt_s OPT_RST = '0;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_RESP = 2'b10
	} bus_e;

endpackage

// File: test/board_model.sv
// board side model of the port pins: external drivers, weak pull-ups, floating lines
`timescale 1ns/10ps
`default_nettype none

module board_model
	import gpio_pkg::*;
(
	// clock
	input wire logic clk,
	// from the port block
	input wire pins_s pin_o,
	input wire pins_s pin_oe_n,
	input wire pins_s pull_en,
	// external circuitry
	input wire pins_s ext_val,
	input wire pins_s ext_en,
	// resolved levels
	output pins_s pin_i
);
	pins_s float_q = '0;

	// an undriven line without pull-up wanders every cycle
	always @(posedge clk) begin
		float_q <= ~float_q;
	end

	// block drive wins, then the board, then the pull-up
	assign pin_i = (~pin_oe_n & pin_o) |
		(pin_oe_n & ext_en & ext_val) |
		(pin_oe_n & ~ext_en & pull_en) |
		(pin_oe_n & ~ext_en & ~pull_en & float_q);
endmodule

`default_nettype wire

// File: test/test_bidirectional_io_ports.sv
// self-checking testbench of the bidirectional io port block
`timescale 1ns/10ps
`default_nettype none

module test_bidirectional_io_ports
	import gpio_pkg::*;
;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = '0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	pins_s pin_i, pin_o, pin_oe_n, pull_en;
	pins_s ext_val = '1;
	pins_s ext_en = '1;
	logic ext_int_n, sys_clk_en, irq;
	logic [7:0] analog_switch_lines;
	logic [3:0] osc_drive = '0;
	logic [3:0] osc_drive_oe_n = '1;
	logic [3:0] osc_sense;
	logic [31:0] exp_q[$];
	logic [31:0] e;
	logic [7:0] r, x;
	integer err_total = 0;
	integer checked = 0;
	integer seed = 76811;
	integer i;

	always #5 clk = ~clk;

	gpio_ports #(.SMALL_VARIANT(1'b0)) gpio_ports_inst (.clk(clk), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pull_en(pull_en),
		.ext_int_n(ext_int_n), .analog_switch_lines(analog_switch_lines),
		.osc_drive(osc_drive), .osc_drive_oe_n(osc_drive_oe_n), .osc_sense(osc_sense),
		.sys_clk_en(sys_clk_en), .irq(irq));

	board_model board_model_inst (.clk(clk), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.pull_en(pull_en), .ext_val(ext_val), .ext_en(ext_en), .pin_i(pin_i));

	// ********************
	// reporting
	// ********************
	task automatic fail(input string m);
		err_total++;
		$display("Error at %0t: %s", $time, m);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail($sformatf("pin got %h want %h", got, exp));
		end
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ********************
	// avalon master
	// ********************
	// request held until the rising edge that samples waitrequest low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= 4'hf;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge clk);
		end while (avs_waitrequest);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		exp_q.push_back(exp);
		bus(1'b0, a, '0);
	endtask

	task automatic settle(input integer n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	// read results are compared against the oldest note
	always @(posedge clk) begin
		if (avs_read && !avs_waitrequest) begin
			e = exp_q.pop_front();
			checked++;
			if (avs_readdata !== e) begin
				fail($sformatf("read %h got %h want %h", avs_address, avs_readdata, e));
			end
		end
	end

	initial begin
		#100000;
		fail("watchdog expired");
		give_verdict();
	end

	// ********************
	// scenarios
	// ********************
	initial begin
		@(posedge clk);
		ext_val <= pins_s'(28'($random(seed)));
		repeat (15) @(posedge clk);
		srst <= 1'b0;
		settle(1);
		chk(pin_oe_n, SYNC_RST);
		chk(pin_o, SYNC_RST);
		chk(pull_en, '0);
		for (i = 0; i < 4; i++) begin
			rd(ADDR_DIR + 8'(4 * i), PORT_MASK[i]);
			rd(ADDR_DATA + 8'(4 * i), {4'h0, ext_val} >> (8 * i) & PORT_MASK[i]);
		end
		rd(8'h40, '0);
		rd(ADDR_BITOP, '0);
		$display("test reset done");
		ext_val.a <= 8'hff;
		wr(ADDR_MASK, 32'h3);
		wr(ADDR_OPT0, 32'h0110);
		wr(ADDR_PWR, 32'h1);
		settle(2);
		chk(sys_clk_en, 1'b0);
		@(posedge clk);
		ext_val.a <= 8'hfd;
		settle(6);
		chk(sys_clk_en, 1'b0);
		@(posedge clk);
		ext_val.a <= 8'hfc;
		settle(6);
		chk(sys_clk_en, 1'b1);
		chk(irq, 1'b1);
		rd(ADDR_STAT, 32'h1);
		wr(ADDR_STAT, 32'h1);
		settle(2);
		chk(irq, 1'b0);
		@(posedge clk);
		ext_val.a <= 8'hdc;
		settle(6);
		chk(ext_int_n, 1'b0);
		chk(irq, 1'b1);
		rd(ADDR_STAT, 32'h2);
		wr(ADDR_MASK, 32'h0);
		settle(2);
		chk(irq, 1'b0);
		$display("test wake done");
		r = 8'($random(seed));
		x = 8'($random(seed));
		@(posedge clk);
		ext_val.a <= ~r;
		wr(ADDR_OPT0, 32'h1);
		wr(ADDR_DIR, 32'h0);
		wr(ADDR_DATA, r);
		settle(1);
		chk(pin_oe_n.a, 8'h00);
		chk(pin_o.a, r);
		chk(pull_en.a, 8'h00);
		rd(ADDR_DATA, r);
		wr(ADDR_DIR, 32'h0f);
		settle(3);
		chk(pull_en.a, 8'h0f);
		chk(pin_o.a[7:4], r[7:4]);
		rd(ADDR_DATA, {r[7:4], ~r[3:0]});
		$display("test direction done");
		ext_val.b <= x;
		wr(ADDR_DIR + 8'h4, 32'hf0);
		wr(ADDR_DATA + 8'h4, 32'h05);
		wr(ADDR_BITOP, 32'h91);
		rd(ADDR_DATA + 8'h4, {x[7:4], 4'h7});
		wr(ADDR_DIR + 8'h4, 32'h0);
		settle(1);
		chk(pin_o.b, {x[7:4], 4'h7});
		rd(ADDR_DIR + 8'h4, 32'h0);
		wr(ADDR_BITOP, 32'h62);
		rd(ADDR_DIR + 8'h8, 32'hfb);
		$display("test bit op done");
		osc_drive <= 4'($random(seed));
		osc_drive_oe_n <= 4'h0;
		wr(ADDR_DIR + 8'h8, 32'h0);
		wr(ADDR_OPT1, 32'h0fff);
		settle(3);
		chk(pin_oe_n.c, 8'hff);
		chk(analog_switch_lines, ext_val.c);
		chk(pin_o.d, osc_drive);
		chk(osc_sense, osc_drive);
		$display("test sharing done");
		give_verdict();
	end
endmodule

`default_nettype wire
